//--- design/mem_protect_pkg.sv
/*
  Shared constants for the region memory protection unit: register map,
  field positions, reset values, permission codes and access kinds.
  Assumes a 32-bit core address space and 32-bit register data.
*/
package mem_protect_pkg;
  localparam int NUM_REGIONS = 8;
  localparam int ADDR_W = 32;
  localparam int REG_ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] FAULT_ADDR_OFS = 8'h0c;
  localparam logic [7:0] FAULT_INFO_OFS = 8'h10;
  localparam logic [7:0] REGION_BASE_OFS = 8'h20;
  localparam logic [7:0] REGION_STRIDE = 8'h08;
  localparam logic [7:0] REGION_ATTR_SUB = 8'h04;
  localparam logic [7:0] REGION_END_OFS = 8'h60;

  // Control register fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DEFPRIV_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_DEFPRIV_RST = 1'b1;

  // Status and mask fields
  localparam int STAT_W = 2;
  localparam int STAT_PERM_BIT = 0;
  localparam int STAT_MISS_BIT = 1;

  // Region attribute fields
  localparam int ATTR_EN_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_SIZE_W = 5;
  localparam int ATTR_PERM_LSB = 8;
  localparam int PERM_W = 3;
  localparam int ATTR_EXEC_NEVER_BIT = 12;
  localparam logic [4:0] SIZE_MIN = 5'h04;

  // Permission codes
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_PRW = 3'h1;
  localparam logic [2:0] PERM_PRW_URO = 3'h2;
  localparam logic [2:0] PERM_FULL = 3'h3;
  localparam logic [2:0] PERM_PRO = 3'h5;
  localparam logic [2:0] PERM_RO = 3'h6;

  // Access kinds
  localparam logic [1:0] ACC_READ = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_FETCH = 2'h2;
endpackage

//--- design/region_memory_protection.sv
/*
  Region memory protection unit: checks each core access against eight
  prioritised regions and a default region and grants or faults it.
  Assumes the core holds an access until acc_done_o and lets it proceed
  only when acc_grant_o is high. Registers sit on a plain strobe port.
*/
`timescale 1ns/1ps
module region_memory_protection
  import mem_protect_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [mem_protect_pkg::REG_ADDR_W-1:0] bus_addr_i,
  input wire logic [mem_protect_pkg::DATA_W-1:0] bus_wdata_i,
  input wire logic bus_we_i,
  input wire logic bus_re_i,
  input wire logic bus_priv_i,
  output logic [mem_protect_pkg::DATA_W-1:0] bus_rdata_o,
  input wire logic acc_valid_i,
  input wire logic [mem_protect_pkg::ADDR_W-1:0] acc_addr_i,
  input wire logic [1:0] acc_kind_i,
  input wire logic acc_priv_i,
  output logic acc_done_o,
  output logic acc_grant_o,
  output logic memory_fault_handler_o,
  output logic irq_o
);
  import mem_protect_pkg::*;

  logic ctrl_en_reg;
  logic ctrl_defpriv_reg;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [ADDR_W-1:0] fault_addr_reg;
  logic [2:0] fault_info_reg;
  logic [ADDR_W-1:0] base_reg [NUM_REGIONS];
  logic rgn_en_reg [NUM_REGIONS];
  logic rgn_exec_never_reg [NUM_REGIONS];
  logic [ATTR_SIZE_W-1:0] rgn_size_reg [NUM_REGIONS];
  logic [PERM_W-1:0] rgn_perm_reg [NUM_REGIONS];

  logic [NUM_REGIONS-1:0] hit_vec;
  logic any_hit;
  logic [2:0] top_idx;
  logic [PERM_W-1:0] top_perm;
  logic top_exec_never;
  logic rd_ok;
  logic wr_ok;
  logic allow;
  logic miss_fault;
  logic perm_fault;
  logic cfg_wr;
  logic [DATA_W-1:0] rdata_next;

  // Configuration writes need privileged software
  assign cfg_wr = bus_we_i && bus_priv_i;

  // Address match of every region; size field gives 2^(size+1) bytes
  always_comb begin
    logic [5:0] shamt;
    logic [ADDR_W-1:0] mask;
    shamt = '0;
    mask = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      shamt = {1'b0, rgn_size_reg[i]} + 6'h01;
      mask = {ADDR_W{1'b1}} << shamt;
      hit_vec[i] = rgn_en_reg[i] &&
                   ((acc_addr_i & mask) == (base_reg[i] & mask));
    end
  end

  // Priority pick: later index overrides earlier, so region 7 wins
  always_comb begin
    any_hit = 1'b0;
    top_idx = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit_vec[i]) begin
        any_hit = 1'b1;
        top_idx = 3'(i);
      end
    end
    top_perm = rgn_perm_reg[top_idx];
    top_exec_never = rgn_exec_never_reg[top_idx];
  end

  // Access matrix: read and write rights per privilege level
  always_comb begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    unique case (top_perm)
      PERM_NONE: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
      PERM_PRW: begin
        rd_ok = acc_priv_i;
        wr_ok = acc_priv_i;
      end
      PERM_PRW_URO: begin
        rd_ok = 1'b1;
        wr_ok = acc_priv_i;
      end
      PERM_FULL: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      PERM_PRO: begin
        rd_ok = acc_priv_i;
        wr_ok = 1'b0;
      end
      PERM_RO: begin
        rd_ok = 1'b1;
        wr_ok = 1'b0;
      end
      default: begin
        rd_ok = 1'b0; // Reserved codes deny, the safe choice
        wr_ok = 1'b0;
      end
    endcase
  end

  // Final decision, including default region and global disable
  always_comb begin
    allow = 1'b0;
    miss_fault = 1'b0;
    if (!ctrl_en_reg) begin
      allow = 1'b1;
    end else if (!any_hit) begin
      allow = ctrl_defpriv_reg && acc_priv_i;
      miss_fault = !allow;
    end else if (acc_kind_i == ACC_WRITE) begin
      allow = wr_ok;
    end else if (acc_kind_i == ACC_FETCH) begin
      allow = rd_ok && !top_exec_never;
    end else begin
      allow = rd_ok;
    end
    perm_fault = ctrl_en_reg && any_hit && !allow;
  end

  // Access answer one cycle after the request; core waits for it
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      acc_done_o <= 1'b0;
      acc_grant_o <= 1'b0;
      memory_fault_handler_o <= 1'b0;
    end else begin
      acc_done_o <= acc_valid_i;
      acc_grant_o <= acc_valid_i && allow;
      memory_fault_handler_o <= acc_valid_i && !allow;
    end
  end

  // Fault capture for the handler: address, kind and privilege
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      fault_addr_reg <= '0;
      fault_info_reg <= '0;
    end else if (acc_valid_i && !allow) begin
      fault_addr_reg <= acc_addr_i;
      fault_info_reg <= {acc_priv_i, acc_kind_i};
    end
  end

  // Sticky status; a new fault beats a same-cycle write-one clear
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg &
                     ~((cfg_wr && bus_addr_i == STATUS_OFS) ?
                       bus_wdata_i[STAT_W-1:0] : '0)) |
                    {acc_valid_i && miss_fault,
                     acc_valid_i && perm_fault};
    end
  end

  // Interrupt level from masked status
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  // Control and mask registers; reset leaves protection on, users denied
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl_en_reg <= CTRL_EN_RST;
      ctrl_defpriv_reg <= CTRL_DEFPRIV_RST;
      mask_reg <= '0;
    end else if (cfg_wr) begin
      if (bus_addr_i == CTRL_OFS) begin
        ctrl_en_reg <= bus_wdata_i[CTRL_EN_BIT];
        ctrl_defpriv_reg <= bus_wdata_i[CTRL_DEFPRIV_BIT];
      end
      if (bus_addr_i == MASK_OFS) begin
        mask_reg <= bus_wdata_i[STAT_W-1:0];
      end
    end
  end

  // Region registers; all regions come up disabled with no access
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        base_reg[i] <= '0;
        rgn_en_reg[i] <= 1'b0;
        rgn_exec_never_reg[i] <= 1'b1;
        rgn_size_reg[i] <= SIZE_MIN;
        rgn_perm_reg[i] <= PERM_NONE;
      end
    end else if (cfg_wr) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        if (bus_addr_i == REGION_BASE_OFS + REGION_STRIDE * 8'(i)) begin
          base_reg[i] <= bus_wdata_i;
        end
        if (bus_addr_i == REGION_BASE_OFS + REGION_STRIDE * 8'(i) +
            REGION_ATTR_SUB) begin
          rgn_en_reg[i] <= bus_wdata_i[ATTR_EN_BIT];
          rgn_exec_never_reg[i] <= bus_wdata_i[ATTR_EXEC_NEVER_BIT];
          // Sizes below the minimum granule are raised to it
          rgn_size_reg[i] <=
            (bus_wdata_i[ATTR_SIZE_LSB +: ATTR_SIZE_W] < SIZE_MIN) ?
            SIZE_MIN : bus_wdata_i[ATTR_SIZE_LSB +: ATTR_SIZE_W];
          rgn_perm_reg[i] <= bus_wdata_i[ATTR_PERM_LSB +: PERM_W];
        end
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    if (bus_addr_i == CTRL_OFS) begin
      rdata_next[CTRL_EN_BIT] = ctrl_en_reg;
      rdata_next[CTRL_DEFPRIV_BIT] = ctrl_defpriv_reg;
    end else if (bus_addr_i == STATUS_OFS) begin
      rdata_next[STAT_W-1:0] = status_reg;
    end else if (bus_addr_i == MASK_OFS) begin
      rdata_next[STAT_W-1:0] = mask_reg;
    end else if (bus_addr_i == FAULT_ADDR_OFS) begin
      rdata_next = fault_addr_reg;
    end else if (bus_addr_i == FAULT_INFO_OFS) begin
      rdata_next[2:0] = fault_info_reg;
    end else if (bus_addr_i >= REGION_BASE_OFS &&
                 bus_addr_i < REGION_END_OFS) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        if (bus_addr_i == REGION_BASE_OFS + REGION_STRIDE * 8'(i)) begin
          rdata_next = base_reg[i];
        end
        if (bus_addr_i == REGION_BASE_OFS + REGION_STRIDE * 8'(i) +
            REGION_ATTR_SUB) begin
          rdata_next[ATTR_EN_BIT] = rgn_en_reg[i];
          rdata_next[ATTR_EXEC_NEVER_BIT] = rgn_exec_never_reg[i];
          rdata_next[ATTR_SIZE_LSB +: ATTR_SIZE_W] = rgn_size_reg[i];
          rdata_next[ATTR_PERM_LSB +: PERM_W] = rgn_perm_reg[i];
        end
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      bus_rdata_o <= '0;
    end else if (bus_re_i) begin
      bus_rdata_o <= rdata_next;
    end else begin
      bus_rdata_o <= '0;
    end
  end

  // Checks on the decision path, the control write lock and the interrupt
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_disabled_grant;
    acc_valid_i && !ctrl_en_reg |=> acc_grant_o && !memory_fault_handler_o;
  endproperty
  a_disabled_grant: assert property (p_disabled_grant)
    else $error("Access faulted while protection disabled");

  property p_top_region;
    hit_vec[7] |-> top_idx == 3'h7;
  endproperty
  a_top_region: assert property (p_top_region)
    else $error("Region 7 hit but not chosen");

  property p_no_access;
    acc_valid_i && ctrl_en_reg && any_hit && top_perm == PERM_NONE
      |=> memory_fault_handler_o && !acc_grant_o;
  endproperty
  a_no_access: assert property (p_no_access)
    else $error("No-access region granted an access");

  property p_exec_never_fetch;
    acc_valid_i && ctrl_en_reg && any_hit && top_exec_never &&
      acc_kind_i == ACC_FETCH |=> !acc_grant_o;
  endproperty
  a_exec_never_fetch: assert property (p_exec_never_fetch)
    else $error("Fetch granted from execute-never region");

  property p_user_write_ro;
    acc_valid_i && ctrl_en_reg && any_hit && !acc_priv_i &&
      top_perm == PERM_PRW_URO && acc_kind_i == ACC_WRITE
      |=> memory_fault_handler_o;
  endproperty
  a_user_write_ro: assert property (p_user_write_ro)
    else $error("User write granted in user read-only region");

  property p_ro_write;
    acc_valid_i && ctrl_en_reg && any_hit && top_perm == PERM_RO &&
      acc_kind_i == ACC_WRITE |=> memory_fault_handler_o;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("Write granted in read-only region");

  property p_default_deny;
    acc_valid_i && ctrl_en_reg && !any_hit && !ctrl_defpriv_reg
      |=> memory_fault_handler_o ##1 status_reg[STAT_MISS_BIT];
  endproperty
  a_default_deny: assert property (p_default_deny)
    else $error("Unmatched access not faulted and recorded");

  property p_answer;
    acc_valid_i |=> acc_done_o && (acc_grant_o != memory_fault_handler_o);
  endproperty
  a_answer: assert property (p_answer)
    else $error("Access answer missing or ambiguous");

  property p_cfg_lock;
    bus_we_i && !bus_priv_i && bus_addr_i == CTRL_OFS
      |=> $stable(ctrl_en_reg) && $stable(ctrl_defpriv_reg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("Unprivileged write changed control");

  property p_irq;
    |(status_reg & mask_reg) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt not raised for masked status");

  c_perm_fault: cover property (acc_valid_i && perm_fault);
  c_miss_fault: cover property (acc_valid_i && miss_fault);
  c_overlap: cover property (acc_valid_i && hit_vec[7] && hit_vec[0]);
  c_grant_fetch: cover property (acc_valid_i &&
                                 acc_kind_i == ACC_FETCH && allow);
endmodule

//--- sim/core_access_model.sv
/*
  Core-side model: issues one memory access for each one-cycle go pulse.
  Assumes the bench raises go_i for single cycles with gaps between them.
*/
`timescale 1ns/1ps
module core_access_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [mem_protect_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] kind_i,
  input wire logic priv_i,
  output logic acc_valid_o,
  output logic [mem_protect_pkg::ADDR_W-1:0] acc_addr_o,
  output logic [1:0] acc_kind_o,
  output logic acc_priv_o
);
  import mem_protect_pkg::*;

  // Quiet start so the block sees no request before reset ends
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = '0;
    acc_kind_o = 2'h0;
    acc_priv_o = 1'b0;
  end

  // One-cycle request; idle lines toggle so stale values never pass
  always @(posedge sys_clk_i) begin
    acc_valid_o <= go_i;
    acc_addr_o <= go_i ? addr_i : ~acc_addr_o;
    acc_kind_o <= go_i ? kind_i : ~acc_kind_o;
    acc_priv_o <= go_i ? priv_i : ~acc_priv_o;
  end
endmodule

//--- sim/region_memory_protection_bench.sv
/*
  Self-checking bench for the region memory protection unit.
  Assumes the core model above and a 40 MHz single clock domain.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module region_memory_protection_bench;
  import mem_protect_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] b_addr = 8'h00;
  logic [31:0] b_wdata = 32'h0;
  logic b_we = 1'b0;
  logic b_re = 1'b0;
  logic b_priv = 1'b1;
  logic [31:0] b_rdata;
  logic go = 1'b0;
  logic [31:0] g_addr = 32'h0;
  logic [1:0] g_kind = 2'h0;
  logic g_priv = 1'b0;
  logic a_valid;
  logic [31:0] a_addr;
  logic [1:0] a_kind;
  logic a_priv;
  logic done;
  logic grant;
  logic fault;
  logic irq;
  int fail_count = 0;
  int cmp_count = 0;

  // 25 ns period
  always #12.5 clk = ~clk;

  core_access_model core (.sys_clk_i(clk), .go_i(go), .addr_i(g_addr),
    .kind_i(g_kind), .priv_i(g_priv), .acc_valid_o(a_valid),
    .acc_addr_o(a_addr), .acc_kind_o(a_kind), .acc_priv_o(a_priv));

  region_memory_protection dut (.sys_clk_i(clk), .reset_n_i(rst_n),
    .bus_addr_i(b_addr), .bus_wdata_i(b_wdata), .bus_we_i(b_we),
    .bus_re_i(b_re), .bus_priv_i(b_priv), .bus_rdata_o(b_rdata),
    .acc_valid_i(a_valid), .acc_addr_i(a_addr), .acc_kind_i(a_kind),
    .acc_priv_i(a_priv), .acc_done_o(done), .acc_grant_o(grant),
    .memory_fault_handler_o(fault), .irq_o(irq));

  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic p);
    @(posedge clk);
    b_we <= 1'b1;
    b_addr <= a;
    b_wdata <= d;
    b_priv <= p;
    @(posedge clk);
    b_we <= 1'b0;
    b_priv <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    b_re <= 1'b1;
    b_addr <= a;
    @(posedge clk);
    b_re <= 1'b0;
    #1;
    `CHK("rdata", e, b_rdata)
  endtask

  // One core access through the model; answer lands two edges later
  task automatic acc(input logic [31:0] a, input logic [1:0] k,
                     input logic p, input logic g);
    @(posedge clk);
    go <= 1'b1;
    g_addr <= a;
    g_kind <= k;
    g_priv <= p;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("done", 1'b1, done)
    `CHK("grant", g, grant)
    `CHK("fault", ~g, fault)
  endtask

  function automatic logic [7:0] rb(input int i);
    return REGION_BASE_OFS + REGION_STRIDE * 8'(i);
  endfunction

  function automatic logic [31:0] attr(input logic en, input logic [4:0] sz,
                                       input logic [2:0] pm,
                                       input logic exec_never);
    return {19'h0, exec_never, 1'b0, pm, 2'b00, sz, en};
  endfunction

  // Expected right: fetch follows read unless execute-never is set
  function automatic logic allow(input logic [2:0] pm, input logic exec_never,
                                 input logic p, input logic [1:0] k);
    logic r;
    logic w;
    r = (pm == PERM_PRW || pm == PERM_PRO) ? p :
        (pm == PERM_PRW_URO || pm == PERM_FULL || pm == PERM_RO);
    w = (pm == PERM_PRW || pm == PERM_PRW_URO) ? p : (pm == PERM_FULL);
    return (k == ACC_WRITE) ? w : (k == ACC_FETCH) ? (r && !exec_never) : r;
  endfunction

  task automatic t_reset();
    rd(CTRL_OFS, 32'h3);
    rd(rb(3) + REGION_ATTR_SUB, attr(1'b0, SIZE_MIN, PERM_NONE, 1'b1));
    rd(STATUS_OFS, 32'h0);
    rd(8'h80, 32'h0);
    wr(CTRL_OFS, 32'h0, 1'b0);
    rd(CTRL_OFS, 32'h3);
  endtask

  task automatic t_default();
    acc(32'h2000_0000, ACC_READ, 1'b1, 1'b1);
    acc(32'h2000_0000, ACC_READ, 1'b0, 1'b0);
    rd(STATUS_OFS, 32'h2);
    wr(CTRL_OFS, 32'h1, 1'b1);
    acc(32'h2000_0000, ACC_FETCH, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h3, 1'b1);
    wr(STATUS_OFS, 32'h3, 1'b1);
    rd(STATUS_OFS, 32'h0);
  endtask

  task automatic t_disable();
    wr(rb(0), 32'h3000_0000, 1'b1);
    wr(rb(0) + REGION_ATTR_SUB, attr(1'b1, 5'h0b, PERM_NONE, 1'b1), 1'b1);
    acc(32'h3000_0004, ACC_READ, 1'b1, 1'b0);
    wr(STATUS_OFS, 32'h3, 1'b1);
    wr(CTRL_OFS, 32'h0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      acc(32'h3000_0004, 2'(k), 1'b0, 1'b1);
      acc(32'h5000_0000, 2'(k), 1'b0, 1'b1);
    end
    rd(STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h3, 1'b1);
  endtask

  // Every permission code with both execute-never settings
  task automatic t_matrix();
    logic [2:0] codes [6];
    codes = '{PERM_NONE, PERM_PRW, PERM_PRW_URO,
              PERM_FULL, PERM_PRO, PERM_RO};
    wr(rb(0), 32'h1000_0000, 1'b1);
    for (int c = 0; c < 6; c++) begin
      for (int x = 0; x < 2; x++) begin
        wr(rb(0) + REGION_ATTR_SUB, attr(1'b1, 5'h0b, codes[c], x[0]), 1'b1);
        for (int p = 0; p < 2; p++) begin
          for (int k = 0; k < 3; k++) begin
            acc(32'h1000_0ff0, 2'(k), p[0],
                allow(codes[c], x[0], p[0], 2'(k)));
          end
        end
      end
    end
    // Reserved codes must deny even a privileged read
    wr(rb(0) + REGION_ATTR_SUB, attr(1'b1, 5'h0b, 3'h4, 1'b0), 1'b1);
    acc(32'h1000_0ff0, ACC_READ, 1'b1, 1'b0);
    wr(rb(0) + REGION_ATTR_SUB, attr(1'b1, 5'h0b, 3'h7, 1'b0), 1'b1);
    acc(32'h1000_0ff0, 2'h3, 1'b1, 1'b0);
    rd(STATUS_OFS, 32'h1);
    wr(STATUS_OFS, 32'h1, 1'b1);
    wr(rb(0) + REGION_ATTR_SUB, 32'h0, 1'b1);
  endtask

  // All eight regions stacked; even ones open, odd ones closed
  task automatic t_priority();
    for (int i = 0; i < 8; i++) begin
      wr(rb(i), 32'h4000_0000, 1'b1);
      wr(rb(i) + REGION_ATTR_SUB,
         attr(1'b1, 5'h0b, (i % 2) ? PERM_NONE : PERM_FULL, 1'b0), 1'b1);
    end
    for (int j = 7; j >= 0; j--) begin
      acc(32'h4000_0010, ACC_WRITE, 1'b0, (j % 2) == 0);
      wr(rb(j) + REGION_ATTR_SUB, 32'h0, 1'b1);
    end
    acc(32'h4000_0010, ACC_WRITE, 1'b0, 1'b0);
    wr(STATUS_OFS, 32'h3, 1'b1);
  endtask

  // Raise, capture, clear and mask the fault interrupt
  task automatic t_irq();
    wr(MASK_OFS, 32'h2, 1'b1);
    acc(32'h6000_0008, ACC_WRITE, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    rd(FAULT_ADDR_OFS, 32'h6000_0008);
    rd(FAULT_INFO_OFS, 32'h1);
    wr(STATUS_OFS, 32'h2, 1'b1);
    // The interrupt level trails the cleared status by one edge
    @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    wr(MASK_OFS, 32'h1, 1'b1);
    acc(32'h6000_0008, ACC_READ, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    wr(MASK_OFS, 32'h3, 1'b1);
    @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(STATUS_OFS, 32'h2, 1'b1);
    wr(MASK_OFS, 32'h0, 1'b1);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compared, %0d failed", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_default();
    t_disable();
    t_matrix();
    t_priority();
    t_irq();
    wrap_up();
  end

  // Whole run needs about 450 cycles; cut a hang well past that
  initial begin
    repeat (8000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
